// [verilog/svtf_formatter.sv]
// Purpose: line and field timing with timing reference codes and 4:2:2 multiplex
// Assumes: ref_clk is the luma sampling clock; config ports from same-clock logic
// Notes: mode is taken at reset and at each frame end; inputs are read while pix_req
//
// How it works
// - ten-bit words have two fraction bits; eight-bit inputs get two zeros appended
// - picture words clipped into 1.00 to 254.75; reserved levels never sent
// - luma and RGB black is 16.00, nominal peak 235.00
// - colour-difference achromatic at 128.00, extremes at 16.00 and 240.00
// - one-way link from this single source to one destination
// - words pair Cb1/Y1, Cr1/Y2, Cb3/Y3, Cr3/Y4 and onward
// - chroma sampled at half rate, co-sited with odd luma samples
// - 1125-line mode also carries RGB as three ten-bit lanes
// - line is 2200 clocks (1125) or 2304 clocks (1250)
// - end code starts 88 or 128 clocks before sync reference
// - start code ends and video begins 192 or 256 clocks after it
// - line blanking lasts 280 or 384 clocks, rest is active video
// - each code is four words: three preamble, then flag word
// - codes abut the video block and run on every blanking line
// - eight-bit codes use bits 9..2; 1250-line codes use all ten
// - field and vertical bits change only at the line-opening end code
// - four protection bits let receiver fix one, detect two errors
// - flag word holds F, V, H as a number, F most significant
// - 1125 mode: active 41-557 and 603-1120; field 2 from 564
// - 1250 mode: active 45-620 and 670-1245; field 2 from 626
`timescale 1ns/10ps
module svtf_formatter
  import svtf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // configuration
  input wire logic mode_1250,
  input wire logic eight_bit,
  input wire logic rgb_mode,
  input wire logic [1:0] pattern_sel,
  // picture samples, read while pix_req is high
  input wire logic [9:0] y_in,
  input wire logic [9:0] cb_in,
  input wire logic [9:0] cr_in,
  input wire logic [9:0] r_in,
  // source pacing
  output logic pix_req,
  // one-way output stream and its flags
  output logic [9:0] word_y,
  output logic [9:0] word_c,
  output logic [9:0] word_r,
  output logic code_flag,
  output logic active_out,
  output logic hblank_out,
  output logic fld_out,
  output logic vblank_out,
  output logic [10:0] line_out
);

  logic mode_q;
  logic eight_q;
  logic [11:0] cnt;
  logic [10:0] line;
  logic fld;
  logic vblank;
  logic [9:0] cr_hold;
  logic [11:0] out_pos;
  logic [11:0] hb_len;
  logic [11:0] len;
  logic [11:0] blank;
  logic [10:0] frame_last;
  logic [10:0] next_line;
  logic line_end;
  logic in_eav;
  logic in_sav;
  logic in_act;
  logic even_slot;
  logic rgb_ok;
  logic h_bit;
  logic [9:0] code_mask;
  logic [9:0] flag_word;
  logic [9:0] code_word;
  logic [9:0] next_y;
  logic [9:0] next_c;
  logic [9:0] next_r;

  // scale an input word to quarter steps and keep it off reserved levels
  function automatic logic [9:0] to_video(input logic [9:0] v, input logic e8);
    logic [9:0] w;
    w = e8 ? {v[7:0], 2'b00} : v;
    if (w < LVL_MIN) begin
      w = LVL_MIN;
    end else if (e8 && w > LVL_MAX_8) begin
      w = LVL_MAX_8;
    end else if (w > LVL_MAX) begin
      w = LVL_MAX;
    end
    return w;
  endfunction

  // field identification for a line number
  function automatic logic field_of(input logic [10:0] ln, input logic m);
    return m ? (ln >= F2_FIRST_1250) : (ln >= F2_FIRST_1125);
  endfunction

  // vertical blanking for a line number
  function automatic logic vblank_of(input logic [10:0] ln, input logic m);
    logic act;
    if (m) begin
      act = (ln >= F1_ACT_FIRST_1250 && ln <= F1_ACT_LAST_1250) ||
            (ln >= F2_ACT_FIRST_1250 && ln <= F2_ACT_LAST_1250);
    end else begin
      act = (ln >= F1_ACT_FIRST_1125 && ln <= F1_ACT_LAST_1125) ||
            (ln >= F2_ACT_FIRST_1125 && ln <= F2_ACT_LAST_1125);
    end
    return !act;
  endfunction

  // mode-dependent line geometry
  assign len = mode_q ? LINE_LEN_1250 : LINE_LEN_1125;
  assign blank = mode_q ? BLANK_1250 : BLANK_1125;
  assign frame_last = mode_q ? FRAME_LAST_1250 : FRAME_LAST_1125;
  assign line_end = (cnt == len - 12'h001);
  assign next_line = (line == frame_last) ? FIRST_LINE : 11'(line + 11'h001);
  // end code opens the line, start code closes the blanking
  assign in_eav = (cnt < CODE_LEN);
  assign in_sav = (cnt >= blank - CODE_LEN) && (cnt < blank);
  assign in_act = (cnt >= blank);
  assign even_slot = !cnt[0]; // blanking length is even
  assign rgb_ok = rgb_mode && !mode_q;

  // fourth code word: F, V, H then protection bits
  assign h_bit = in_eav;
  assign flag_word = {1'b1, fld, vblank, h_bit,
                      vblank ^ h_bit, fld ^ h_bit, fld ^ vblank,
                      fld ^ vblank ^ h_bit, 2'b00};
  assign code_mask = (eight_q && !mode_q) ? CODE8_MASK : 10'h3FF;

  // pick the code word for the current slot
  always_comb begin
    case (cnt[1:0])
      2'h0: code_word = PREAMBLE_ONES & code_mask;
      2'h1: code_word = PREAMBLE_ZERO;
      2'h2: code_word = PREAMBLE_ZERO;
      default: code_word = flag_word & code_mask;
    endcase
  end

  // picture lane values, by pattern selection
  always_comb begin
    next_y = LVL_BLACK;
    next_c = LVL_CHROMA_MID;
    next_r = LVL_BLACK;
    case (svtf_pat_e'(pattern_sel))
      SVTF_PAT_PASS: begin
        next_y = to_video(y_in, eight_q);
        if (rgb_ok) begin
          next_c = to_video(cb_in, eight_q);
          next_r = to_video(r_in, eight_q);
        end else if (even_slot) begin
          next_c = to_video(cb_in, eight_q);
        end else begin
          next_c = cr_hold;
        end
      end
      SVTF_PAT_BLACK: next_y = LVL_BLACK;
      SVTF_PAT_PEAK: begin
        next_y = LVL_PEAK;
        next_r = rgb_ok ? LVL_PEAK : LVL_BLACK;
        next_c = rgb_ok ? LVL_PEAK : LVL_CHROMA_MID;
      end
      SVTF_PAT_CHROMA: next_c = even_slot ? LVL_CHROMA_HIGH : LVL_CHROMA_LOW;
      default: next_y = LVL_BLACK;
    endcase
  end

  // sample and line counters; mode taken at reset and at frame boundaries
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt <= 12'h000;
      line <= FIRST_LINE;
      mode_q <= mode_1250;
      eight_q <= eight_bit;
    end else if (line_end) begin
      cnt <= 12'h000;
      line <= next_line;
      if (line == frame_last) begin
        mode_q <= mode_1250;
        eight_q <= eight_bit;
      end
    end else begin
      cnt <= 12'(cnt + 12'h001);
    end
  end

  // field and vertical bits move only as the next line opens
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fld <= 1'b0;
      vblank <= 1'b1;
    end else if (line_end) begin
      fld <= field_of(next_line, (next_line == FIRST_LINE) ? mode_1250 : mode_q);
      vblank <= vblank_of(next_line, (next_line == FIRST_LINE) ? mode_1250 : mode_q);
    end
  end

  // hold the co-sited red difference for the following word
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cr_hold <= LVL_CHROMA_MID;
    end else if (in_act && even_slot) begin
      cr_hold <= to_video(cr_in, eight_q);
    end
  end

  // output words and flags, aligned with each other
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      word_y <= LVL_BLACK;
      word_c <= LVL_CHROMA_MID;
      word_r <= LVL_BLACK;
      code_flag <= 1'b0;
      active_out <= 1'b0;
      hblank_out <= 1'b1;
      fld_out <= 1'b0;
      vblank_out <= 1'b1;
      line_out <= FIRST_LINE;
      out_pos <= 12'h000;
    end else begin
      if (in_eav || in_sav) begin
        word_y <= code_word;
        word_c <= code_word;
        word_r <= code_word;
      end else if (in_act && !vblank) begin
        word_y <= next_y;
        word_c <= next_c;
        word_r <= next_r;
      end else begin
        word_y <= LVL_BLACK;
        word_c <= rgb_ok ? LVL_BLACK : LVL_CHROMA_MID;
        word_r <= LVL_BLACK;
      end
      code_flag <= in_eav || in_sav;
      active_out <= in_act && !vblank;
      hblank_out <= !in_act;
      fld_out <= fld;
      vblank_out <= vblank;
      line_out <= line;
      out_pos <= cnt;
    end
  end

  // source pacing: high while this cycle's inputs become the next word
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pix_req <= 1'b0;
    end else begin
      pix_req <= !line_end && (cnt + 12'h001 >= blank) && !vblank;
    end
  end

  // blanking run length, read only by checks
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hb_len <= 12'h000; // first blanking word after release then counts as one
    end else if (!in_act) begin
      hb_len <= hblank_out ? 12'(hb_len + 12'h001) : 12'h001;
    end
  end

  // code sequences seen on the luma lane
  sequence s_preamble;
    code_flag && word_y == (PREAMBLE_ONES & code_mask) ##1
    code_flag && word_y == PREAMBLE_ZERO ##1
    code_flag && word_y == PREAMBLE_ZERO;
  endsequence
  sequence s_flag_word;
    code_flag && word_y[9] && word_y[1:0] == 2'b00;
  endsequence
  property p_code_shape;
    @(posedge ref_clk) disable iff (rst)
      code_flag && (out_pos == 12'h000 || out_pos == blank - CODE_LEN) |-> // not reset value
      s_preamble ##1 s_flag_word;
  endproperty
  a_code_shape: assert property (p_code_shape) else $error("timing code shape wrong");
  property p_protect;
    @(posedge ref_clk) disable iff (rst)
      (code_flag && out_pos[1:0] == 2'h3) |->
      word_y[5] == (word_y[7] ^ word_y[6]) && word_y[4] == (word_y[8] ^ word_y[6]) &&
      word_y[3] == (word_y[8] ^ word_y[7]) && word_y[2] == (^word_y[8:6]);
  endproperty
  a_protect: assert property (p_protect) else $error("protection bits wrong");

  property p_h_bit;
    @(posedge ref_clk) disable iff (rst)
      (code_flag && out_pos[1:0] == 2'h3) |-> word_y[6] == (out_pos < CODE_LEN);
  endproperty
  a_h_bit: assert property (p_h_bit) else $error("H bit wrong in code");

  property p_video_range;
    @(posedge ref_clk) disable iff (rst)
      active_out |-> word_y >= LVL_MIN && word_y <= LVL_MAX &&
                     word_c >= LVL_MIN && word_c <= LVL_MAX;
  endproperty
  a_video_range: assert property (p_video_range) else $error("reserved level as video");

  property p_blank_black;
    @(posedge ref_clk) disable iff (rst)
      (!active_out && !code_flag) |-> word_y == LVL_BLACK;
  endproperty
  a_blank_black: assert property (p_blank_black) else $error("blanking not black");

  property p_sav_abuts;
    @(posedge ref_clk) disable iff (rst)
      (code_flag && out_pos == blank - 12'h001) || out_pos == len - 12'h001 |=>
      hblank_out == code_flag && hblank_out == (out_pos == 12'h000);
  endproperty
  a_sav_abuts: assert property (p_sav_abuts) else $error("codes not abutting video");
  property p_blank_len;
    @(posedge ref_clk) disable iff (rst)
      (out_pos == blank - 12'h001) |-> hb_len == blank;
  endproperty
  a_blank_len: assert property (p_blank_len) else $error("line blanking length wrong");

  property p_fv_stable;
    @(posedge ref_clk) disable iff (rst)
      (out_pos != 12'h000) |-> $stable(fld_out) && $stable(vblank_out);
  endproperty
  a_fv_stable: assert property (p_fv_stable) else $error("F or V changed mid-line");

  property p_field;
    @(posedge ref_clk) disable iff (rst)
      (out_pos == 12'h000) |->
      fld_out == (line_out >= (mode_q ? F2_FIRST_1250 : F2_FIRST_1125));
  endproperty
  a_field: assert property (p_field) else $error("field bit disagrees with line");

endmodule

// [verilog/svtf_pkg.sv]
// Purpose: shared constants of the studio video timing formatter
// Assumes: 10-bit words, levels scaled by four (two fractional bits)
// Notes: line positions count from the first word of the end code
package svtf_pkg;
  // line timing in sample clocks, 1125-line and 1250-line modes
  localparam logic [11:0] LINE_LEN_1125 = 12'h898;
  localparam logic [11:0] LINE_LEN_1250 = 12'h900;
  localparam logic [11:0] EAV_TO_REF_1125 = 12'h058;
  localparam logic [11:0] EAV_TO_REF_1250 = 12'h080;
  localparam logic [11:0] REF_TO_ACT_1125 = 12'h0C0;
  localparam logic [11:0] REF_TO_ACT_1250 = 12'h100;
  localparam logic [11:0] BLANK_1125 = 12'(EAV_TO_REF_1125 + REF_TO_ACT_1125);
  localparam logic [11:0] BLANK_1250 = 12'(EAV_TO_REF_1250 + REF_TO_ACT_1250);
  localparam logic [11:0] CODE_LEN = 12'h004;
  // field line numbers, 1125-line mode
  localparam logic [10:0] F1_ACT_FIRST_1125 = 11'h029;
  localparam logic [10:0] F1_ACT_LAST_1125 = 11'h22D;
  localparam logic [10:0] F2_FIRST_1125 = 11'h234;
  localparam logic [10:0] F2_ACT_FIRST_1125 = 11'h25B;
  localparam logic [10:0] F2_ACT_LAST_1125 = 11'h460;
  localparam logic [10:0] FRAME_LAST_1125 = 11'h465;
  // field line numbers, 1250-line mode
  localparam logic [10:0] F1_ACT_FIRST_1250 = 11'h02D;
  localparam logic [10:0] F1_ACT_LAST_1250 = 11'h26C;
  localparam logic [10:0] F2_FIRST_1250 = 11'h272;
  localparam logic [10:0] F2_ACT_FIRST_1250 = 11'h29E;
  localparam logic [10:0] F2_ACT_LAST_1250 = 11'h4DD;
  localparam logic [10:0] FRAME_LAST_1250 = 11'h4E2;
  localparam logic [10:0] FIRST_LINE = 11'h001;
  // quantization levels in quarter steps
  localparam logic [9:0] LVL_MIN = 10'h004;
  localparam logic [9:0] LVL_MAX = 10'h3FB;
  localparam logic [9:0] LVL_MAX_8 = 10'h3F8;
  localparam logic [9:0] LVL_BLACK = 10'h040;
  localparam logic [9:0] LVL_PEAK = 10'h3AC;
  localparam logic [9:0] LVL_CHROMA_MID = 10'h200;
  localparam logic [9:0] LVL_CHROMA_LOW = 10'h040;
  localparam logic [9:0] LVL_CHROMA_HIGH = 10'h3C0;
  // timing code words
  localparam logic [9:0] PREAMBLE_ONES = 10'h3FF;
  localparam logic [9:0] PREAMBLE_ZERO = 10'h000;
  localparam logic [9:0] CODE8_MASK = 10'h3FC;
  // test pattern selections
  typedef enum logic [1:0] {
    SVTF_PAT_PASS, SVTF_PAT_BLACK, SVTF_PAT_PEAK, SVTF_PAT_CHROMA
  } svtf_pat_e;
endpackage

// [dv/svtf_sink.sv]
// Purpose: stream destination model that checks every received word
// Assumes: outputs settle before the falling edge of ref_clk
// Notes: mode pins are latched while reset is seen, as the formatter takes them
`timescale 1ns/10ps
module svtf_sink
  import svtf_pkg::*;
(
  // clock, reset and run config
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mode_1250,
  input wire logic eight_bit,
  // received stream
  input wire logic [9:0] word_y,
  input wire logic [9:0] word_c,
  input wire logic [9:0] word_r,
  input wire logic code_flag,
  input wire logic active_out,
  input wire logic hblank_out,
  input wire logic fld_out,
  input wire logic vblank_out,
  input wire logic [10:0] line_out,
  input wire logic pix_req,
  // tallies
  output int n_bad,
  output int n_seen
);
  logic rst_q;
  logic f, v, h, cd, act, m, e8;
  logic [9:0] w;
  int p, ln, len, blk;
  initial n_bad = 0;
  initial n_seen = 0;
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] s);
    n_seen++;
    if (s !== e) begin
      n_bad++;
      $display("MISMATCH %s line %0d pos %0d expected %h seen %h", nm, ln, p, e, s);
    end
  endtask
  // this end only listens: nothing is ever driven back
  always @(posedge ref_clk) rst_q <= rst;
  // one word per edge, judged where settled
  always @(negedge ref_clk) begin
    len = m ? 2304 : 2200;
    blk = m ? 384 : 280;
    if (rst_q !== 1'b0) begin
      p = 0;
      ln = 1;
      m = mode_1250;
      e8 = eight_bit;
    end else begin
      f = m ? ln >= 626 : ln >= 564;
      act = m ? (ln >= 45 && ln <= 620) || (ln >= 670 && ln <= 1245)
        : (ln >= 41 && ln <= 557) || (ln >= 603 && ln <= 1120);
      v = !act;
      h = p < 4;
      cd = p < 4 || (p >= blk - 4 && p < blk);
      w = (p % 4 == 3) ? {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00}
        : (p % 4 != 0) ? PREAMBLE_ZERO
        : (e8 && !m) ? CODE8_MASK : PREAMBLE_ONES;
      chk("code_flag", 11'(cd), 11'(code_flag));
      if (cd) begin
        chk("code_y", 11'(w), 11'(word_y));
        chk("code_c", 11'(w), 11'(word_c));
        chk("code_r", 11'(w), 11'(word_r));
      end else if (p < blk || v) begin
        chk("blank_y", 11'(LVL_BLACK), 11'(word_y));
        chk("blank_c", 11'(LVL_CHROMA_MID), 11'(word_c));
        chk("blank_r", 11'(LVL_BLACK), 11'(word_r));
      end else begin
        chk("range", 11'd1, 11'(word_y >= LVL_MIN && word_y <= LVL_MAX &&
          word_c >= LVL_MIN && word_c <= LVL_MAX));
      end
      chk("hblank", 11'(p < blk), 11'(hblank_out));
      chk("active", 11'(act && p >= blk), 11'(active_out));
      chk("pix_req", 11'(act && p >= blk - 1 && p <= len - 2), 11'(pix_req));
      chk("fld", 11'(f), 11'(fld_out));
      chk("vblank", 11'(v), 11'(vblank_out));
      chk("line", 11'(ln), line_out);
      p = p + 1;
      if (p == len) begin
        p = 0;
        ln = (ln == (m ? 1250 : 1125)) ? 1 : ln + 1;
      end
    end
  end
endmodule

// [dv/svtf_formatter_bench.sv]
// Purpose: self-checking bench for the timing formatter
// Assumes: 250 MHz ref_clk, synchronous active-high reset
// Notes: reaches the first active line of the 1125 mode only
`timescale 1ns/10ps
module svtf_formatter_bench
  import svtf_pkg::*;
;
  logic ref_clk, rst, mode_1250, eight_bit, rgb_mode, pix_req, code_flag, active_out;
  logic hblank_out, fld_out, vblank_out;
  logic [1:0] pattern_sel;
  logic [9:0] y_in, cb_in, cr_in, r_in, word_y, word_c, word_r, ey, ec, er, hold;
  logic [10:0] line_out;
  logic [42:0] e;
  logic [42:0] q[$];
  logic [2:0] last = 3'b000;
  int n_errors = 0, n_compared = 0, sink_bad, sink_seen, k = 0, n_act = 0, st = 0, cyc = 0;
  svtf_formatter DUT (.ref_clk(ref_clk), .rst(rst), .mode_1250(mode_1250),
    .eight_bit(eight_bit), .rgb_mode(rgb_mode), .pattern_sel(pattern_sel), .y_in(y_in),
    .cb_in(cb_in), .cr_in(cr_in), .r_in(r_in), .pix_req(pix_req), .word_y(word_y),
    .word_c(word_c), .word_r(word_r), .code_flag(code_flag), .active_out(active_out),
    .hblank_out(hblank_out), .fld_out(fld_out), .vblank_out(vblank_out), .line_out(line_out));
  svtf_sink sink (.ref_clk(ref_clk), .rst(rst), .mode_1250(mode_1250), .eight_bit(eight_bit),
    .word_y(word_y), .word_c(word_c), .word_r(word_r), .code_flag(code_flag),
    .active_out(active_out), .hblank_out(hblank_out), .fld_out(fld_out),
    .vblank_out(vblank_out), .line_out(line_out), .pix_req(pix_req), .n_bad(sink_bad),
    .n_seen(sink_seen));
  // clock and time-zero inputs
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    {rst, mode_1250, eight_bit, rgb_mode, pattern_sel} <= 6'h28;
    {y_in, cb_in, cr_in, r_in} <= 40'h0;
  end
  task automatic cmp(input string nm, input logic [10:0] x, input logic [10:0] s);
    n_compared++;
    if (s !== x) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask
  // eight-bit sample with zeros appended, kept inside the picture range
  function automatic logic [9:0] clip8(input logic [9:0] v);
    clip8 = (v[7:0] == 8'h00) ? LVL_MIN : (v[7:0] == 8'hFF) ? LVL_MAX_8 : {v[7:0], 2'b00};
  endfunction
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared + sink_seen, n_errors + sink_bad);
    if (n_errors + sink_bad == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // reset for 17 cycles with the given mode, then release
  task automatic do_reset(input logic m, input logic e8);
    @(posedge ref_clk);
    rst <= 1'b1;
    mode_1250 <= m;
    eight_bit <= e8;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    cmp("rst_code", 11'd0, 11'(code_flag));
    cmp("rst_req", 11'd0, 11'(pix_req));
    cmp("rst_line", 11'd1, line_out);
    @(posedge ref_clk);
    rst <= 1'b0;
  endtask
  // run limit: a hang counts as a mismatch and goes to the report
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      n_errors++;
      close_out();
    end
  end
  // feed a fresh sample each edge the formatter reads one, segment by segment
  always @(posedge ref_clk) begin
    if (pix_req === 1'b1) begin
      q.push_back({pattern_sel, rgb_mode, y_in, cb_in, cr_in, r_in});
      k = k + 1;
    end
    y_in <= {2'b00, 8'(k)};
    cb_in <= {2'b00, ~8'(k)};
    cr_in <= {2'b00, 8'(k + 85)};
    r_in <= {2'b00, 8'(k) ^ 8'hA5};
    rgb_mode <= k >= 640 && k < 960;
    pattern_sel <= k < 960 ? 2'd0 : k < 1280 ? 2'd1 : k < 1600 ? 2'd2 : 2'd3;
  end
  // compare each active word with the sample that fed it, skipping the first two words of each segment after the first
  always @(negedge ref_clk) begin
    if (active_out === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      st = (e[42:40] != last) ? 2 : (st > 0 ? st - 1 : 0);
      last = e[42:40];
      if (n_act[0] == 1'b0) hold = e[19:10];
      ey = e[42:41] == 2'd0 ? clip8(e[39:30]) : e[42:41] == 2'd2 ? LVL_PEAK : LVL_BLACK;
      ec = (e[40] || !n_act[0]) ? clip8(e[29:20]) : clip8(hold);
      if (e[42:41] == 2'd3) ec = n_act[0] ? LVL_CHROMA_LOW : LVL_CHROMA_HIGH;
      if (e[42:41] == 2'd1 || e[42:41] == 2'd2) ec = LVL_CHROMA_MID;
      er = e[40] ? clip8(e[9:0]) : LVL_BLACK;
      if (st == 0) begin
        cmp("word_y", 11'(ey), 11'(word_y));
        cmp("word_c", 11'(ec), 11'(word_c));
        cmp("word_r", 11'(er), 11'(word_r));
      end
      n_act = n_act + 1;
    end
  end
  // eight-bit 1125 run through blanking lines into the first active line
  task automatic sc_first_active();
    do_reset(1'b0, 1'b1);
    while (line_out !== 11'd41) @(negedge ref_clk);
    while (active_out !== 1'b1) @(negedge ref_clk);
    while (active_out === 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    cmp("active_words", 11'd1920, 11'(n_act));
    cmp("samples_read", 11'd1920, 11'(k));
  endtask
  // mid-run reset into 1250 mode: ten-bit codes although eight_bit is high
  task automatic sc_mode_1250();
    do_reset(1'b1, 1'b1);
    repeat (2314) @(posedge ref_clk);
    @(negedge ref_clk);
    cmp("line_1250", 11'd2, line_out);
  endtask
  // ten-bit 1125 line length
  task automatic sc_ten_bit();
    do_reset(1'b0, 1'b0);
    repeat (2210) @(posedge ref_clk);
    @(negedge ref_clk);
    cmp("line_1125", 11'd2, line_out);
  endtask
  initial begin
    sc_first_active();
    sc_mode_1250();
    sc_ten_bit();
    close_out();
  end
endmodule
